// >>> include/iocfg_pkg.sv
// package: constants and carriers for the port access block
package iocfg_pkg;
   localparam int ADDR_W = 24;
   localparam logic [23:0] MEM_LO = 24'h00_0000;
   localparam logic [23:0] MEM_HI = 24'hff_ffff;
   localparam logic [23:0] IO_HI = 24'h00_ffff;
   localparam logic [23:0] COPRO_LO = 24'h80_00f8;
   localparam logic [23:0] COPRO_HI = 24'h80_00ff;
   localparam logic [15:0] PORT_INDEX = 16'h0022;
   localparam logic [15:0] PORT_DATA = 16'h0023;
   localparam logic [7:0] IDX_LO = 8'hc0;
   localparam logic [7:0] IDX_HI = 8'hcf;
   localparam int CFG_N = 16;
   localparam logic [7:0] CFG_RST = 8'h00;
   localparam logic [7:0] IDX_RST = 8'h00;

   typedef enum logic [1:0] {KIND_MEM, KIND_IO, KIND_ESCAPE} iocfg_kind_t;
   typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_DWORD} iocfg_size_t;

   typedef struct packed {
      iocfg_kind_t kind;
      logic write;
      iocfg_size_t size;
      logic [23:0] addr;
      logic [31:0] data;
   } iocfg_req_t;

   typedef struct packed {
      logic memNotIo;
      logic write;
      iocfg_size_t size;
      logic [23:0] addr;
      logic [31:0] data;
   } iocfg_ext_t;
endpackage : iocfg_pkg

// >>> logic/iocfg_port_access.sv
// address-space decode and configuration port handling
`timescale 1ns/1ns
// Function
// - decode 24-bit memory space, 16 MBytes
// - port accesses limited to 64 KByte range
// - coprocessor ports at upper I/O F8-FF
// - escape opcode generates coprocessor port accesses
// - I/O transfers of 8, 16, 32 bits
// - port instructions drive memory/IO select low
// - upper eight address bits low for port instructions, 80h for coprocessor ports
// - on-chip register accesses run no external cycle
// - data access on-chip only after index write
// - out-of-range index writes go external
// - index port reads always go external
// - memory accesses of byte, word, doubleword
// - little-endian items addressed by lowest byte
module iocfg_port_access (
   input wire logic clk,
   input wire logic srst,
   input wire logic ce,
   input wire logic reqValid,
   input wire iocfg_pkg::iocfg_req_t req,
   output logic extValid,
   output iocfg_pkg::iocfg_ext_t ext,
   output logic intDone,
   output logic [7:0] intRdata,
   output logic idxValid
);
   logic extValid_r, extValid_nxt;
   iocfg_pkg::iocfg_ext_t ext_r, ext_nxt;
   logic intDone_r, intDone_nxt;
   logic [7:0] rdata_r, rdata_nxt;
   logic [7:0] idx_r, idx_nxt;
   logic idxVld_r, idxVld_nxt;
   logic cfgWr;
   logic [7:0] cfg_r [iocfg_pkg::CFG_N];
   logic [15:0] port;
   logic idxInRange;

   assign port = req.addr[15:0];
   assign idxInRange = (req.data[7:0] >= iocfg_pkg::IDX_LO) &&
      (req.data[7:0] <= iocfg_pkg::IDX_HI);

   always_comb begin
      extValid_nxt = 1'b0;
      ext_nxt = ext_r;
      intDone_nxt = 1'b0;
      rdata_nxt = rdata_r;
      idx_nxt = idx_r;
      idxVld_nxt = idxVld_r;
      cfgWr = 1'b0;
      if (reqValid) begin
         ext_nxt.write = req.write;
         ext_nxt.size = req.size;
         ext_nxt.data = req.data;
         case (req.kind)
            iocfg_pkg::KIND_MEM: begin
               extValid_nxt = 1'b1;
               ext_nxt.memNotIo = 1'b1;
               ext_nxt.addr = req.addr;
            end
            iocfg_pkg::KIND_ESCAPE: begin
               extValid_nxt = 1'b1;
               ext_nxt.memNotIo = 1'b0;
               ext_nxt.addr = iocfg_pkg::COPRO_LO |
                  {21'h0, req.addr[2:0]};
            end
            iocfg_pkg::KIND_IO: begin
               ext_nxt.memNotIo = 1'b0;
               ext_nxt.addr = {8'h00, port};
               if (port == iocfg_pkg::PORT_INDEX && req.write &&
                   idxInRange) begin
                  intDone_nxt = 1'b1;
                  idx_nxt = req.data[7:0];
                  idxVld_nxt = 1'b1;
               end else if (port == iocfg_pkg::PORT_DATA && idxVld_r) begin
                  intDone_nxt = 1'b1;
                  idxVld_nxt = 1'b0;
                  cfgWr = req.write;
                  if (!req.write) begin
                     rdata_nxt = cfg_r[idx_r[3:0]];
                  end
               end else begin
                  extValid_nxt = 1'b1;
                  if (port == iocfg_pkg::PORT_INDEX && req.write) begin
                     idxVld_nxt = 1'b0;
                  end
               end
            end
            default: begin
               extValid_nxt = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         extValid_r <= 1'b0;
         ext_r <= '0;
         intDone_r <= 1'b0;
         rdata_r <= iocfg_pkg::CFG_RST;
         idx_r <= iocfg_pkg::IDX_RST;
         idxVld_r <= 1'b0;
      end else if (ce) begin
         extValid_r <= extValid_nxt;
         ext_r <= ext_nxt;
         intDone_r <= intDone_nxt;
         rdata_r <= rdata_nxt;
         idx_r <= idx_nxt;
         idxVld_r <= idxVld_nxt;
      end
   end

   // configuration register storage
   genvar gi;
   generate
      for (gi = 0; gi < iocfg_pkg::CFG_N; gi++) begin : g_cfg
         logic [7:0] cfgNxt;
         always_comb begin
            cfgNxt = cfg_r[gi];
            if (cfgWr && idx_r[3:0] == 4'(gi)) begin
               cfgNxt = req.data[7:0];
            end
         end
         always_ff @(posedge clk) begin
            if (srst) begin
               cfg_r[gi] <= iocfg_pkg::CFG_RST;
            end else if (ce) begin
               cfg_r[gi] <= cfgNxt;
            end
         end
      end
   endgenerate

   assign extValid = extValid_r;
   assign ext = ext_r;
   assign intDone = intDone_r;
   assign intRdata = rdata_r;
   assign idxValid = idxVld_r;

   // checks
   sequence sIdxWrite;
      ce && reqValid && req.kind == iocfg_pkg::KIND_IO && req.write &&
      port == iocfg_pkg::PORT_INDEX && idxInRange;
   endsequence
   sequence sDataAccess;
      ce && reqValid && req.kind == iocfg_pkg::KIND_IO &&
      port == iocfg_pkg::PORT_DATA;
   endsequence
   sequence sDataWrite;
      ce && reqValid && req.kind == iocfg_pkg::KIND_IO && req.write &&
      port == iocfg_pkg::PORT_DATA;
   endsequence
   sequence sDataRead;
      ce && reqValid && req.kind == iocfg_pkg::KIND_IO && !req.write &&
      port == iocfg_pkg::PORT_DATA;
   endsequence

   AST_MEM_PASS: assert property (@(posedge clk) disable iff (srst)
      ce && reqValid && req.kind == iocfg_pkg::KIND_MEM |=>
      extValid && ext.memNotIo && ext.addr == $past(req.addr) &&
      ext.size == $past(req.size))
      else $error("memory access not forwarded intact");
   AST_PORT_UPPER: assert property (@(posedge clk) disable iff (srst)
      ce && reqValid && req.kind == iocfg_pkg::KIND_IO |=>
      ext.addr[23:16] == 8'h00 && ext.addr <= iocfg_pkg::IO_HI)
      else $error("port address upper bits not low");
   AST_ESCAPE_COPRO: assert property (@(posedge clk) disable iff (srst)
      ce && reqValid && req.kind == iocfg_pkg::KIND_ESCAPE |=>
      extValid && !ext.memNotIo && ext.addr >= iocfg_pkg::COPRO_LO &&
      ext.addr <= iocfg_pkg::COPRO_HI)
      else $error("escape did not reach coprocessor ports");
   AST_IO_SELECT: assert property (@(posedge clk) disable iff (srst)
      ce && reqValid && req.kind == iocfg_pkg::KIND_IO |=> !ext.memNotIo)
      else $error("port access marked as memory");
   AST_NO_DOUBLE: assert property (@(posedge clk) disable iff (srst)
      !(intDone && extValid))
      else $error("internal access also ran external cycle");
   AST_IDX_THEN_DATA: assert property (@(posedge clk)
      disable iff (srst)
      sIdxWrite ##1 sDataAccess |=> intDone && !extValid && !idxValid)
      else $error("data access after index write not internal");
   AST_DATA_STALE: assert property (@(posedge clk) disable iff (srst)
      sDataAccess and !idxValid |=> extValid && !intDone)
      else $error("stale data access not forwarded");
   AST_IDX_RANGE: assert property (@(posedge clk) disable iff (srst)
      ce && reqValid && req.kind == iocfg_pkg::KIND_IO && req.write &&
      port == iocfg_pkg::PORT_INDEX && !idxInRange |=>
      extValid && !idxValid)
      else $error("out-of-range index handled on-chip");
   AST_IDX_READ: assert property (@(posedge clk) disable iff (srst)
      ce && reqValid && req.kind == iocfg_pkg::KIND_IO && !req.write &&
      port == iocfg_pkg::PORT_INDEX |=> extValid && !intDone)
      else $error("index read not forwarded");
   AST_IDX_SET: assert property (@(posedge clk) disable iff (srst)
      sIdxWrite |=> idxValid && intDone)
      else $error("valid index write not taken");

   AST_CFG_WRITE: assert property (@(posedge clk) disable iff (srst)
      sIdxWrite ##1 sDataWrite |=>
      cfg_r[$past(idx_r[3:0])] == $past(req.data[7:0]))
      else $error("config register write lost");
   AST_CFG_READ: assert property (@(posedge clk) disable iff (srst)
      sIdxWrite ##1 sDataRead |=>
      intDone && intRdata == cfg_r[$past(idx_r[3:0])])
      else $error("config register read wrong");
   AST_SIZE_PASS: assert property (@(posedge clk) disable iff (srst)
      ce && reqValid |=> ext.size == $past(req.size) &&
      ext.write == $past(req.write) && ext.data == $past(req.data))
      else $error("transfer width or data not forwarded");
   AST_IDLE_QUIET: assert property (@(posedge clk) disable iff (srst)
      ce && !reqValid |=> !extValid && !intDone)
      else $error("answer without request");
   AST_CE_FREEZE: assert property (@(posedge clk) disable iff (srst)
      !ce |=> $stable(extValid) && $stable(intDone) && $stable(idxValid) &&
      $stable(intRdata) && $stable(ext))
      else $error("state moved while clock enable low");
   AST_IDX_KEEP: assert property (@(posedge clk) disable iff (srst)
      ce && reqValid && req.kind == iocfg_pkg::KIND_MEM |=>
      idxValid == $past(idxValid))
      else $error("memory access disturbed stored index");
endmodule : iocfg_port_access

// >>> sim/iocfg_ext_model.sv
// partner model: external bus side, counts external i/o cycles
`timescale 1ns/1ns
module iocfg_ext_model (
   input wire logic clk,
   input wire logic extValid,
   input wire iocfg_pkg::iocfg_ext_t ext,
   output int nIo
);
   int cnt = 0;
   assign nIo = cnt;
   always @(posedge clk) begin
      if (extValid === 1'b1 && ext.memNotIo === 1'b0) cnt <= cnt + 1;
   end
endmodule : iocfg_ext_model

// >>> sim/tb_iocfg_port_access.sv
// bench: reference model compared with the port access block
`timescale 1ns/1ns
module tb_iocfg_port_access;
   logic clk = 1'b0, srst = 1'b1, ce = 1'b1, reqValid = 1'b0;
   iocfg_pkg::iocfg_req_t req = '0;
   logic extValid, intDone, idxValid;
   iocfg_pkg::iocfg_ext_t ext;
   logic [7:0] intRdata;
   int n_errors = 0, total_checks = 0, nIo, expIo = 0, n = 0;
   int cfg [16], idx, idxOk, rd;
   logic [15:0] lf = 16'h7b53;
   always #20 clk = ~clk;
   iocfg_port_access u_dut (.clk(clk), .srst(srst), .ce(ce),
      .reqValid(reqValid), .req(req), .extValid(extValid), .ext(ext),
      .intDone(intDone), .intRdata(intRdata), .idxValid(idxValid));
   iocfg_ext_model u_bus (.clk(clk), .extValid(extValid), .ext(ext),
      .nIo(nIo));
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : give_verdict
   task automatic do_reset();
      srst = 1'b1;
      reqValid = 1'b0;
      foreach (cfg[i]) cfg[i] = 0;
      idxOk = 0;
      repeat (2) @(posedge clk);
      #1 srst = 1'b0;
      @(posedge clk);
      #1 chk(idxValid, 0);
   endtask : do_reset
   task automatic acc(input iocfg_pkg::iocfg_kind_t k, input logic w,
         input logic [23:0] a, input logic [31:0] d);
      logic ex;
      logic [23:0] ea;
      iocfg_pkg::iocfg_size_t sz;
      sz = iocfg_pkg::iocfg_size_t'(n % 3);
      n++;
      req = '{k, w, sz, a, d};
      reqValid = 1'b1;
      ex = 1'b1;
      ea = k == iocfg_pkg::KIND_MEM ? a :
         k == iocfg_pkg::KIND_ESCAPE ? 24'h8000f8 + a[2:0] : {8'h00, a[15:0]};
      if (k == iocfg_pkg::KIND_IO && a[15:0] == 16'h0022 && w) begin
         ex = !(d[7:0] inside {[8'hc0:8'hcf]});
         idxOk = !ex;
         idx = d[3:0];
      end else if (k == iocfg_pkg::KIND_IO && a[15:0] == 16'h0023 &&
            idxOk) begin
         ex = 1'b0;
         idxOk = 0;
         if (w) cfg[idx] = d[7:0];
         else rd = cfg[idx];
      end
      if (ex && k != iocfg_pkg::KIND_MEM) expIo++;
      @(posedge clk);
      #1 chk({intDone, extValid}, {!ex, ex});
      chk(idxValid, idxOk);
      if (ex) begin
         chk(ext.memNotIo, k == iocfg_pkg::KIND_MEM);
         chk(ext.addr, ea);
         chk({ext.write, ext.size, ext.data}, {w, sz, d});
      end else if (!w) chk(intRdata, rd[7:0]);
   endtask : acc
   task automatic io(input logic w, input logic [23:0] a, input logic [7:0] d);
      acc(iocfg_pkg::KIND_IO, w, a, {24'h0, d});
   endtask : io
   initial begin
      #80000;
      n_errors++;
      give_verdict();
   end
   initial begin
      do_reset();
      io(0, 24'h23, 0);
      io(1, 24'h22, 8'hc3);
      io(1, 24'h23, 8'h5a);
      io(1, 24'h23, 8'h11);
      io(1, 24'h22, 8'hcf);
      acc(iocfg_pkg::KIND_MEM, 0, 24'hffffff, 32'h12345678);
      io(0, 24'h22, 0);
      io(0, 24'h23, 0);
      io(1, 24'h22, 8'hc3);
      io(0, 24'h23, 0);
      io(1, 24'h22, 8'hd0);
      io(1, 24'h123456, 8'h77);
      for (int k = 0; k < 8; k++)
         acc(iocfg_pkg::KIND_ESCAPE, k[0], k, k);
      reqValid = 1'b0;
      @(posedge clk);
      #1 ce = 1'b0;
      reqValid = 1'b1;
      @(posedge clk);
      #1 chk({intDone, extValid}, 0);
      ce = 1'b1;
      $display("directed test done");
      for (int i = 0; i < 300; i++) begin
         lf = lfsr(lf);
         acc(iocfg_pkg::iocfg_kind_t'(lf[1:0] % 3), lf[2],
            lf[4] ? 24'h22 + lf[5] : {lf[15:8], lf},
            {lf, lf[15:8], lf[7] ? 8'hd5 : {4'hc, lf[11:8]}});
      end
      reqValid = 1'b0;
      @(posedge clk);
      #1 chk(nIo, expIo);
      $display("random test done");
      do_reset();
      io(1, 24'h22, 8'hc3);
      io(0, 24'h23, 0);
      $display("reset test done");
      give_verdict();
   end
endmodule : tb_iocfg_port_access
